// file: verilog/sg_params.svh
/*
  Constants for the envelope generator and port A store of the sound generator:
  register indices, host port numbers, field positions, reset values, counts.
  Assumes it is included by bare name; the guard makes a repeated include harmless.
*/
// Contract
// [R1] Envelope step rate is input clock divided by 256, then by 16-bit period.
// [R2] Coarse register gives period bits 15..8, fine register bits 7..0.
// [R3] Period acts as divisor: one divides by one, all-ones by 65,535.
// [R4] A 4-bit level counter gives sixteen level states per envelope cycle.
// [R5] Only shape register bits 3..0 steer envelope shape and cycling.
// [R6] Freeze set: run one cycle, keep final count 0000 down or 1111 up.
// [R7] Flip set: level counter reverses direction at every cycle end.
// [R8] Freeze and flip both set: return to starting count, then hold.
// [R9] Count upward set: 0000 to 1111; clear: 1111 down to 0000.
// [R10] Keep going clear: drop to 0000 after one cycle and stay there.
// [R11] Envelope level modulates a channel's mixer output when envelope selected.
// [R12] Port data store buffers bus and port A, no effect on sound.
// [R13] Enable register bit 6 set makes port A output, clear input.
// [R14] Host latches the port store index, then reads or writes data.
// [R15] Output mode: pins keep data until rewritten, reset, or input mode.
// [R16] Input mode: port store tracks pins; host sees it by a read.
// [R17] Joystick read at host port F6H; address bits 8/9 pick the stick.
// [R18] Host writes the port store index to port F5H before joystick reads.
// [R19] Channel amplitude is envelope level if mode bit set, else fixed level.
// [R20] Shape bits: 3 keep going, 2 count upward, 1 flip, 0 freeze.
// [R21] Shape write restarts envelope: counters cleared, level at starting count.
// [R22] Period zero acts as one; reset clears envelope and port registers.
`ifndef SG_PARAMS_SVH
`define SG_PARAMS_SVH

`define SG_ADDR_PORT 8'hF5
`define SG_DATA_PORT 8'hF6
`define SG_IDX_ENABLE 4'h7
`define SG_IDX_AMP_A 4'h8
`define SG_IDX_AMP_B 4'h9
`define SG_IDX_AMP_C 4'hA
`define SG_IDX_ENV_FINE 4'hB
`define SG_IDX_ENV_COARSE 4'hC
`define SG_IDX_ENV_SHAPE 4'hD
`define SG_IDX_PORT_A 4'hE
`define SG_REG_RESET 8'h00
`define SG_PORT_DIR_BIT 6
`define SG_AMP_MODE_BIT 4
`define SG_SHAPE_KEEP 3
`define SG_SHAPE_UP 2
`define SG_SHAPE_FLIP 1
`define SG_SHAPE_FREEZE 0
`define SG_JOY_LEFT_BIT 8
`define SG_JOY_RIGHT_BIT 9
`define SG_ENV_PRESCALE 256
`define SG_LEVEL_MAX 4'hF
`define SG_LEVEL_MIN 4'h0

`endif

// file: verilog/sg_pkg.sv
/*
  Types shared by the sound generator envelope and port modules.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package sg_pkg;
  typedef logic [3:0] sg_level_t;
  typedef enum logic [1:0] {
    SG_ENV_RUN  = 2'b01,
    SG_ENV_HOLD = 2'b10
  } sg_env_state_e;
endpackage

// file: verilog/sg_env_if.sv
/*
  Link between the register block and the envelope generator.
  Assumes both ends run on the same clock.
*/
`timescale 1ns/100ps
`default_nettype none
interface sg_env_if;
  import sg_pkg::*;
  logic [15:0] period;
  logic [3:0] shape;
  logic restart;
  sg_level_t level;
  modport ctrl (output period, output shape, output restart, input level);
  modport gen (input period, input shape, input restart, output level);
endinterface
`default_nettype wire

// file: verilog/sg_env_gen.sv
/*
  Envelope generator: prescaler, period divider and 4-bit shaped level counter.
  Assumes period, shape and restart come from registers on the same clock.
*/
`include "sg_params.svh"
`timescale 1ns/100ps
`default_nettype none
module sg_env_gen import sg_pkg::*; #(
  parameter int PRE_DIV = `SG_ENV_PRESCALE
) (
  input wire logic ref_clk_i, // Block clock
  input wire logic sys_rst_i, // Synchronous reset, active high
  sg_env_if.gen env           // Period, shape, restart in; level out
);
  logic [7:0] pre_q;
  logic pre_tick;
  logic [15:0] per_q;
  logic [15:0] per_lim;
  logic step;
  sg_level_t level_q;
  logic up_q;
  sg_env_state_e state_q;
  sg_level_t start_lvl;
  sg_level_t end_lvl;

  assign pre_tick = (pre_q == 8'(PRE_DIV - 1)); // R1
  // A zero period would wrap to a 65,536 divide, so it divides like one
  assign per_lim = (env.period == 16'h0000) ? 16'h0000 : env.period - 16'h0001; // R22 R3
  assign step = pre_tick && (per_q >= per_lim); // R1
  assign start_lvl = env.shape[`SG_SHAPE_UP] ? `SG_LEVEL_MIN : `SG_LEVEL_MAX; // R9
  assign end_lvl = up_q ? `SG_LEVEL_MAX : `SG_LEVEL_MIN;
  assign env.level = level_q;

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || env.restart) begin
      pre_q <= 8'h00; // R21
    end else begin
      pre_q <= pre_tick ? 8'h00 : pre_q + 8'h01;
    end
  end

  // Period may shrink below the running count; >= ends that cycle on the next prescaler tick
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i || env.restart) begin
      per_q <= 16'h0000; // R21
    end else if (pre_tick) begin
      per_q <= step ? 16'h0000 : per_q + 16'h0001; // R3
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      level_q <= `SG_LEVEL_MIN; // R22
      up_q <= 1'b0;
      state_q <= SG_ENV_HOLD;
    end else if (env.restart) begin
      level_q <= start_lvl; // R21
      up_q <= env.shape[`SG_SHAPE_UP]; // R9
      state_q <= SG_ENV_RUN;
    end else if (step) begin
      case (state_q)
        SG_ENV_RUN: begin
          if (level_q != end_lvl) begin
            level_q <= up_q ? level_q + 4'h1 : level_q - 4'h1; // R4 R9
          end else if (!env.shape[`SG_SHAPE_KEEP]) begin
            level_q <= `SG_LEVEL_MIN; // R10
            state_q <= SG_ENV_HOLD;
          end else if (env.shape[`SG_SHAPE_FREEZE]) begin
            state_q <= SG_ENV_HOLD; // R6
            if (env.shape[`SG_SHAPE_FLIP]) begin
              level_q <= start_lvl; // R8
            end
          end else if (env.shape[`SG_SHAPE_FLIP]) begin
            up_q <= ~up_q; // R7
          end else begin
            level_q <= up_q ? `SG_LEVEL_MIN : `SG_LEVEL_MAX;
          end
        end
        SG_ENV_HOLD: begin
          level_q <= level_q;
        end
        default: begin
          state_q <= SG_ENV_HOLD;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// file: verilog/sg_env_port.sv
/*
  Sound generator envelope and port A block: host port decode, register file,
  envelope generator instance, per-channel amplitude select, port A buffer.
  Assumes host strobes are one-cycle pulses synchronous to ref_clk_i.
*/
`include "sg_params.svh"
`timescale 1ns/100ps
`default_nettype none
module sg_env_port import sg_pkg::*; #(
  parameter int CHANNELS = 3,
  parameter int PRE_DIV = `SG_ENV_PRESCALE
) (
  input wire logic ref_clk_i,                   // Block clock, 200 MHz
  input wire logic sys_rst_i,                   // Synchronous reset, active high
  input wire logic [15:0] io_addr_i,            // Host I/O address
  input wire logic io_wr_i,                     // Host I/O write strobe
  input wire logic io_rd_i,                     // Host I/O read strobe
  input wire logic [7:0] shared_bus_lines_i,    // Data bus in
  output logic [7:0] shared_bus_lines_o,        // Data bus out
  output logic shared_bus_lines_oe_o,           // Data bus drive enable
  input wire logic [7:0] port_a_pins_i,         // Port A pin levels
  output logic [7:0] port_a_pins_o,             // Port A drive value
  output logic port_a_pins_oe_o,                // Port A drive enable
  output logic joy_left_sel_o,                  // Left stick select
  output logic joy_right_sel_o,                 // Right stick select
  input wire logic [CHANNELS-1:0] mixer_i,      // Mixer output per channel
  output logic [CHANNELS*4-1:0] chan_level_o,   // Amplitude per channel
  output logic [3:0] envelope_level_out_o       // Envelope level
);
  sg_env_if env_link ();

  logic [3:0] sel_q;
  logic [7:0] enable_q;
  logic [4:0] amp_q [CHANNELS];
  logic [7:0] fine_q;
  logic [7:0] coarse_q;
  logic [7:0] shape_q;
  logic [7:0] port_store_q;
  logic restart_q;
  logic [7:0] rd_data_q;
  logic rd_oe_q;
  logic joy_left_q;
  logic joy_right_q;
  logic [3:0] env_q;
  logic addr_wr;
  logic data_wr;
  logic data_rd;
  logic [7:0] rd_mux;

  assign addr_wr = io_wr_i && (io_addr_i[7:0] == `SG_ADDR_PORT); // R18
  assign data_wr = io_wr_i && (io_addr_i[7:0] == `SG_DATA_PORT); // R14
  assign data_rd = io_rd_i && (io_addr_i[7:0] == `SG_DATA_PORT); // R17

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      sel_q <= 4'h0;
    end else if (addr_wr) begin
      sel_q <= shared_bus_lines_i[3:0]; // R14
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      enable_q <= `SG_REG_RESET;
      fine_q <= `SG_REG_RESET; // R22
      coarse_q <= `SG_REG_RESET;
      shape_q <= `SG_REG_RESET;
    end else if (data_wr) begin
      case (sel_q)
        `SG_IDX_ENABLE: enable_q <= shared_bus_lines_i; // R13
        `SG_IDX_ENV_FINE: fine_q <= shared_bus_lines_i; // R2
        `SG_IDX_ENV_COARSE: coarse_q <= shared_bus_lines_i; // R2
        `SG_IDX_ENV_SHAPE: shape_q <= shared_bus_lines_i;
        default: begin
          enable_q <= enable_q;
        end
      endcase
    end
  end

  generate
    for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          amp_q[ch] <= 5'h00;
        end else if (data_wr && (sel_q == 4'(`SG_IDX_AMP_A + ch))) begin
          amp_q[ch] <= shared_bus_lines_i[4:0];
        end
      end
      // Silent mixer output gives zero, so the level gates the mixer
      always_ff @(posedge ref_clk_i) begin
        if (sys_rst_i) begin
          chan_level_o[ch*4 +: 4] <= 4'h0;
        end else if (!mixer_i[ch]) begin
          chan_level_o[ch*4 +: 4] <= 4'h0; // R11
        end else if (amp_q[ch][`SG_AMP_MODE_BIT]) begin
          chan_level_o[ch*4 +: 4] <= env_link.level; // R19 R11
        end else begin
          chan_level_o[ch*4 +: 4] <= amp_q[ch][3:0]; // R19
        end
      end
    end
  endgenerate

  // Restart is a pulse in the cycle after the shape write strobe, as the new shape lands
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      restart_q <= 1'b0;
    end else begin
      restart_q <= data_wr && (sel_q == `SG_IDX_ENV_SHAPE); // R21
    end
  end

  assign env_link.period = {coarse_q, fine_q}; // R2
  assign env_link.shape = shape_q[3:0]; // R5 R20
  assign env_link.restart = restart_q;

  sg_env_gen #(
    .PRE_DIV(PRE_DIV)
  ) u_env (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .env(env_link)
  );

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      env_q <= 4'h0;
    end else begin
      env_q <= env_link.level; // R4
    end
  end
  assign envelope_level_out_o = env_q;

  // Input mode overwrites the store every cycle, so a host write then is lost
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port_store_q <= `SG_REG_RESET; // R22 R15
    end else if (!enable_q[`SG_PORT_DIR_BIT]) begin
      port_store_q <= port_a_pins_i; // R16
    end else if (data_wr && (sel_q == `SG_IDX_PORT_A)) begin
      port_store_q <= shared_bus_lines_i; // R12 R15
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      port_a_pins_o <= 8'h00;
      port_a_pins_oe_o <= 1'b0;
    end else begin
      port_a_pins_o <= port_store_q; // R15
      port_a_pins_oe_o <= enable_q[`SG_PORT_DIR_BIT]; // R13
    end
  end

  always_comb begin
    case (sel_q)
      `SG_IDX_ENABLE: rd_mux = enable_q;
      `SG_IDX_AMP_A: rd_mux = {3'h0, amp_q[0]};
      `SG_IDX_AMP_B: rd_mux = {3'h0, amp_q[1]};
      `SG_IDX_AMP_C: rd_mux = {3'h0, amp_q[2]};
      `SG_IDX_ENV_FINE: rd_mux = fine_q;
      `SG_IDX_ENV_COARSE: rd_mux = coarse_q;
      `SG_IDX_ENV_SHAPE: rd_mux = shape_q;
      `SG_IDX_PORT_A: rd_mux = port_store_q; // R16
      default: rd_mux = 8'h00;
    endcase
  end

  // Read data is driven for one cycle, the cycle after the strobe
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      rd_data_q <= 8'h00;
      rd_oe_q <= 1'b0;
    end else begin
      rd_oe_q <= data_rd;
      if (data_rd) begin
        rd_data_q <= rd_mux;
      end
    end
  end
  assign shared_bus_lines_o = rd_data_q;
  assign shared_bus_lines_oe_o = rd_oe_q;

  // Stick selects stay at the last data-port read's address bits
  always_ff @(posedge ref_clk_i) begin
    if (sys_rst_i) begin
      joy_left_q <= 1'b0;
      joy_right_q <= 1'b0;
    end else if (data_rd) begin
      joy_left_q <= io_addr_i[`SG_JOY_LEFT_BIT]; // R17
      joy_right_q <= io_addr_i[`SG_JOY_RIGHT_BIT]; // R17
    end
  end
  assign joy_left_sel_o = joy_left_q;
  assign joy_right_sel_o = joy_right_q;
endmodule
`default_nettype wire

// file: verification/sg_env_port_props.sv
/* Concurrent checks on sg_env_port, bound to its ports.
   Assumes PRE_DIV = 4, so one envelope step lasts four cycles or more. */
`timescale 1ns/100ps
`default_nettype none
module sg_env_port_props #(
  parameter int CHANNELS = 3,
  parameter int PRE_DIV = 4
) (
  input wire logic ref_clk_i, // Clock
  input wire logic sys_rst_i, // Reset
  input wire logic [15:0] io_addr_i, // Address
  input wire logic io_wr_i, // Write strobe
  input wire logic io_rd_i, // Read strobe
  input wire logic [7:0] shared_bus_lines_i, // Write data
  input wire logic [7:0] shared_bus_lines_o, // Read data
  input wire logic shared_bus_lines_oe_o, // Read enable
  input wire logic [7:0] port_a_pins_i, // Pins in
  input wire logic [7:0] port_a_pins_o, // Pins out
  input wire logic port_a_pins_oe_o, // Pin enable
  input wire logic joy_left_sel_o, // Left stick
  input wire logic joy_right_sel_o, // Right stick
  input wire logic [CHANNELS-1:0] mixer_i, // Mixer
  input wire logic [CHANNELS*4-1:0] chan_level_o, // Amplitudes
  input wire logic [3:0] envelope_level_out_o // Envelope
);
  default clocking @(posedge ref_clk_i);
  endclocking
  default disable iff (sys_rst_i);
  logic rd_hit;
  assign rd_hit = io_rd_i && (io_addr_i[7:0] == 8'hF6);
  // Eight write-free cycles keep a restart out of the spacing window
  sequence s_quiet;
    !io_wr_i [*8];
  endsequence
  sequence s_held;
    (port_a_pins_oe_o && !io_wr_i) [*3];
  endsequence
  a_read_answer: assert property (rd_hit |=> shared_bus_lines_oe_o)
    else $error("read not answered");
  a_no_stray_drive: assert property (!rd_hit |=> !shared_bus_lines_oe_o)
    else $error("bus driven without read");
  a_left_select: assert property (rd_hit |=> joy_left_sel_o == $past(io_addr_i[8]))
    else $error("left select wrong");
  a_right_select: assert property (rd_hit |=> joy_right_sel_o == $past(io_addr_i[9]))
    else $error("right select wrong");
  a_port_holds: assert property (s_held |-> $stable(port_a_pins_o))
    else $error("port output moved");
  a_dir_by_write: assert property (!$past(sys_rst_i) && $changed(port_a_pins_oe_o) |-> $past(io_wr_i, 2))
    else $error("direction changed without write");
  a_mixer_mutes: assert property (!mixer_i[CHANNELS-1] |=> chan_level_o[CHANNELS*4-1 -: 4] == 4'h0)
    else $error("muted channel has level");
  a_step_spacing: assert property (s_quiet ##0 $changed(envelope_level_out_o) |=> $stable(envelope_level_out_o) [*3])
    else $error("envelope stepped too soon");
endmodule
bind sg_env_port sg_env_port_props #(.CHANNELS(CHANNELS), .PRE_DIV(PRE_DIV)) u_props (
  .ref_clk_i, .sys_rst_i, .io_addr_i, .io_wr_i, .io_rd_i, .shared_bus_lines_i,
  .shared_bus_lines_o, .shared_bus_lines_oe_o, .port_a_pins_i, .port_a_pins_o,
  .port_a_pins_oe_o, .joy_left_sel_o, .joy_right_sel_o, .mixer_i, .chan_level_o,
  .envelope_level_out_o);
`default_nettype wire

// file: verification/sg_host_model.sv
/* Host processor model: address latch, data write and data read cycles.
   Assumes strobes are taken on the rising edge and read data follows one cycle later. */
`timescale 1ns/100ps
`default_nettype none
module sg_host_model (
  input wire logic ref_clk_i, // Clock
  output logic [15:0] io_addr_o, // Address
  output logic io_wr_o, // Write strobe
  output logic io_rd_o, // Read strobe
  output logic [7:0] data_o, // Write data
  input wire logic [7:0] data_i, // Read data
  input wire logic data_oe_i // Read enable
);
  initial begin
    io_addr_o = 16'h0000;
    io_wr_o = 1'b0;
    io_rd_o = 1'b0;
    data_o = 8'h00;
  end
  task automatic put(input logic [15:0] a, input logic [7:0] d);
    @(posedge ref_clk_i);
    #1;
    io_addr_o = a;
    data_o = d;
    io_wr_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    io_wr_o = 1'b0;
    // Released bus shows the inverse so a stale value cannot pass
    data_o = ~d;
  endtask
  task automatic load(input logic [3:0] idx, input logic [7:0] d);
    put(16'h00F5, {4'h0, idx});
    put(16'h00F6, d);
  endtask
  task automatic get(input logic [15:0] a, output logic [7:0] d, output logic oe);
    @(posedge ref_clk_i);
    #1;
    io_addr_o = a;
    io_rd_o = 1'b1;
    @(posedge ref_clk_i);
    #1;
    io_rd_o = 1'b0;
    d = data_i;
    oe = data_oe_i;
  endtask
endmodule
`default_nettype wire

// file: verification/sg_env_port_tb.sv
/* Self-checking bench for sg_env_port: port A both ways, stick selects,
   register readback, all sixteen shapes. Assumes host model and checker compiled first. */
`timescale 1ns/100ps
`default_nettype none
module sg_env_port_tb;
  import sg_pkg::*;
  logic ref_clk_i, sys_rst_i, wr, rd, rd_oe, pins_oe, jl, jr;
  logic [15:0] addr;
  logic [7:0] ext, wdata, rdata, pins_o;
  wire logic [7:0] pin_lvl;
  logic [2:0] mix;
  logic [11:0] chan;
  sg_level_t env;
  int bad_count, n_checks, seed;
  logic [3:0] idx_tab [6] = '{4'hB, 4'hC, 4'hD, 4'h7, 4'h3, 4'hF};
  assign pin_lvl = pins_oe ? pins_o : ext;
  sg_host_model host (.ref_clk_i(ref_clk_i), .io_addr_o(addr), .io_wr_o(wr), .io_rd_o(rd),
    .data_o(wdata), .data_i(rdata), .data_oe_i(rd_oe));
  sg_env_port #(.CHANNELS(3), .PRE_DIV(4)) dut (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .io_addr_i(addr), .io_wr_i(wr), .io_rd_i(rd), .shared_bus_lines_i(wdata),
    .shared_bus_lines_o(rdata), .shared_bus_lines_oe_o(rd_oe), .port_a_pins_i(pin_lvl),
    .port_a_pins_o(pins_o), .port_a_pins_oe_o(pins_oe), .joy_left_sel_o(jl),
    .joy_right_sel_o(jr), .mixer_i(mix), .chan_level_o(chan), .envelope_level_out_o(env));
  function automatic logic [3:0] lev(input logic [3:0] s, input int k);
    logic d;
    d = s[2] ^ (s[1] & k[4]);
    if (k > 15 && !s[3]) return 4'h0;
    if (k > 15 && s[0]) return (s[2] ^ s[1]) ? 4'hF : 4'h0;
    return d ? k[3:0] : ~k[3:0];
  endfunction
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    ref_clk_i = 1'b0;
    forever #2.5 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    repeat (100000) @(posedge ref_clk_i);
    bad_count++;
    stop_test();
  end
  initial begin
    logic [7:0] v, d;
    logic o;
    logic [3:0] prev;
    int k, kold, gap, p;
    seed = 21;
    bad_count = 0;
    n_checks = 0;
    sys_rst_i = 1'b1;
    ext = 8'h00;
    mix = 3'b011;
    repeat (10) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    check({rd_oe, pins_oe, env}, 16'h0000);
    host.load(4'h7, 8'h00);
    host.put(16'h00F5, 8'h0E);
    for (int i = 0; i < 4; i++) begin
      ext = 8'($random(seed));
      host.get({6'h00, i[1:0], 8'hF6}, d, o);
      check({o, d}, {1'b1, ext});
      check({jl, jr}, {i[0], i[1]});
    end
    v = 8'($random(seed));
    host.load(4'h7, 8'h40);
    host.load(4'hE, v);
    ext = ~v;
    repeat (2) @(posedge ref_clk_i);
    #1 check({pins_oe, pins_o}, {1'b1, v});
    host.get(16'h00F6, d, o);
    check(d, v);
    host.load(4'h7, 8'h00);
    repeat (2) @(posedge ref_clk_i);
    #1 check(pins_oe, 1'b0);
    foreach (idx_tab[j]) begin
      v = 8'($random(seed));
      host.load(idx_tab[j], v);
      host.get(16'h00F6, d, o);
      check(d, (idx_tab[j] inside {4'h3, 4'hF}) ? 8'h00 : v);
    end
    host.load(4'h8, 8'h10);
    host.load(4'h9, 8'h07);
    host.load(4'hC, 8'h00);
    for (int s = 0; s < 16; s++) begin
      p = $random(seed) & 3;
      v = 8'($random(seed));
      host.load(4'hB, p[7:0]);
      host.load(4'hD, {v[7:4], s[3:0]});
      repeat (3) @(posedge ref_clk_i);
      #1 check(env, lev(s[3:0], 0));
      prev = env;
      k = 0;
      gap = 0;
      repeat (420) begin
        @(posedge ref_clk_i);
        #1;
        gap++;
        if (env !== prev) begin
          kold = k;
          // A short period gives over a hundred steps in the window
          while (k < 200 && lev(s[3:0], k) === prev) k++;
          check(env, lev(s[3:0], k));
          if (k == kold + 1 && kold > 0) check(16'(gap), 16'(4 * (p == 0 ? 1 : p)));
          prev = env;
          gap = 0;
        end
      end
      if (!s[3] || s[0]) begin
        check(env, lev(s[3:0], 40));
        check(chan, {8'h07, lev(s[3:0], 40)});
      end
    end
    // Mid-run reset must drop the driven port, the selects and the envelope
    host.load(4'h7, 8'h40);
    host.load(4'hE, v);
    @(posedge ref_clk_i);
    #1 check({pins_oe, pins_o}, {1'b1, v});
    sys_rst_i = 1'b1;
    repeat (2) @(posedge ref_clk_i);
    #1 sys_rst_i = 1'b0;
    check({pins_oe, pins_o, env, jl, jr}, 16'h0000);
    check(chan, 16'h0000);
    stop_test();
  end
endmodule
`default_nettype wire
